// [rtl/cdr_dev_end.sv]
// receiver status and control register slice, device end of the register link
// Functional notes
// - status D5 shows input signal lost
// - status D4 one while acquiring, zero locked
// - status D3 shows signal-loss action finished
// - sticky D2 set on unlock, cleared by command
// - D0 set on measurement done, cleared by command
// - mode field: 001 data, 011 reference only
// - control D2 write one clears sticky unlock
// - control D1 write one starts rate measurement
// - control D0 write one discards measurement result
// - software reset: write one then zero
`timescale 1ns/1ns
module cdr_dev_end #(
	parameter logic [7:0] REV_VALUE = 8'h01, // arbitrary value
	parameter logic [7:0] PART_VALUE = 8'h02, // arbitrary value
	parameter logic [7:0] CODE_HI_VALUE = 8'h03, // arbitrary value
	parameter logic [7:0] CODE_LO_VALUE = 8'h04 // arbitrary value
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register link
	cdr_link_if.dev link,
	// analog monitor levels, asynchronous
	input wire logic signal_loss_pin,
	input wire logic lock_loss_pin,
	input wire logic signal_loss_action_done_pin,
	// rate measurement engine, same clock
	input wire logic rate_measure_done_in,
	input wire logic [23:0] rate_value_in,
	// pattern checker, same clock
	input wire logic [7:0] check_err_count,
	input wire logic check_err_flag,
	input wire logic [31:8] check_loaded,
	// mode and command outputs
	output logic [2:0] recovery_mode_select,
	output logic rate_measure_start,
	output logic rate_measure_clear,
	output logic soft_reset,
	// configuration outputs
	output logic [7:0] signal_loss_data,
	output logic [7:0] signal_loss_threshold,
	output logic [7:0] signal_loss_control,
	output logic [7:0] pattern_gen_control,
	output logic [7:0] pattern_gen_length,
	output logic [31:0] pattern_gen_data,
	output logic [7:0] pattern_check_control,
	output logic [7:0] general_control_b
);
	////////////////////////////////////////////////////////////////
	// helpers

	// maps a link address onto a generic storage slot
	function automatic logic [3:0] slot_of(input logic [7:0] a);
		logic [3:0] s;
		s = cdr_pkg::SLOT_NONE;
		if (a == cdr_pkg::ADDR_SIGLOSS_DATA) s = 4'h0;
		else if (a == cdr_pkg::ADDR_SIGLOSS_THRESH) s = cdr_pkg::SLOT_THRESH;
		else if (a == cdr_pkg::ADDR_GEN_CTL) s = 4'h2;
		else if (a == cdr_pkg::ADDR_GEN_LEN) s = 4'h3;
		else if (a == cdr_pkg::ADDR_GEN_B0) s = 4'h4;
		else if (a == cdr_pkg::ADDR_GEN_B1) s = 4'h5;
		else if (a == cdr_pkg::ADDR_GEN_B2) s = 4'h6;
		else if (a == cdr_pkg::ADDR_GEN_B3) s = 4'h7;
		else if (a == cdr_pkg::ADDR_CHK_CTL) s = 4'h8;
		else if (a == cdr_pkg::ADDR_SIGLOSS_CTRL) s = 4'h9;
		else if (a == cdr_pkg::ADDR_CTRLB) s = cdr_pkg::SLOT_CTRLB;
		return s;
	endfunction

	// reset value of a storage slot
	function automatic logic [7:0] rw_default(input int i);
		return (i == int'(cdr_pkg::SLOT_THRESH)) ? cdr_pkg::THRESH_RST : cdr_pkg::RW_RST;
	endfunction

	////////////////////////////////////////////////////////////////
	// monitor inputs

	logic [2:0] pins_s;
	logic lost_s;
	logic unlock_s;
	logic action_done_s;

	cdr_sync2 #(.WIDTH(3)) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.d({signal_loss_pin, lock_loss_pin, signal_loss_action_done_pin}),
		.q(pins_s)
	);

	assign lost_s = pins_s[2];
	assign unlock_s = pins_s[1];
	assign action_done_s = pins_s[0];

	////////////////////////////////////////////////////////////////
	// state

	logic ack_reg, ack_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] mem_reg [cdr_pkg::NUM_RW];
	logic [7:0] mem_next [cdr_pkg::NUM_RW];
	logic [2:0] mode_reg, mode_next;
	logic sticky_reg, sticky_next;
	logic rate_done_reg, rate_done_next;
	logic [23:0] rate_val_reg, rate_val_next;
	logic unlock_d_reg;
	logic start_reg, start_next;
	logic clr_reg, clr_next;
	logic swrst_reg, swrst_next;
	logic take;
	logic wr_ctrl;
	logic [3:0] wslot;
	logic [3:0] rslot;
	logic [7:0] rd_val;

	// a request is taken once; ack drops the cycle after it was given
	assign take = link.req && !ack_reg;
	assign wr_ctrl = take && link.we && (link.addr == cdr_pkg::ADDR_CTRL);
	assign wslot = (take && link.we) ? slot_of(link.addr) : cdr_pkg::SLOT_NONE;
	assign rslot = slot_of(link.addr);

	////////////////////////////////////////////////////////////////
	// read mux, pure selection so a read never disturbs a flag

	always_comb begin
		rd_val = 8'h00;
		if (link.addr == cdr_pkg::ADDR_RATE0) rd_val = rate_val_reg[7:0];
		else if (link.addr == cdr_pkg::ADDR_RATE1) rd_val = rate_val_reg[15:8];
		else if (link.addr == cdr_pkg::ADDR_RATE2) rd_val = rate_val_reg[23:16];
		else if (link.addr == cdr_pkg::ADDR_STATUS) begin
			rd_val[cdr_pkg::ST_LOST] = lost_s;
			rd_val[cdr_pkg::ST_UNLOCK] = unlock_s;
			rd_val[cdr_pkg::ST_SIGLOSS_DONE] = action_done_s;
			rd_val[cdr_pkg::ST_STICKY] = sticky_reg;
			rd_val[cdr_pkg::ST_RATE_DONE] = rate_done_reg;
		end
		else if (link.addr == cdr_pkg::ADDR_CTRL) rd_val = {1'b0, mode_reg, 4'h0};
		else if (link.addr == cdr_pkg::ADDR_CODE_HI) rd_val = CODE_HI_VALUE;
		else if (link.addr == cdr_pkg::ADDR_CODE_LO) rd_val = CODE_LO_VALUE;
		else if (link.addr == cdr_pkg::ADDR_CHK_ERRCNT) rd_val = check_err_count;
		else if (link.addr == cdr_pkg::ADDR_CHK_ERRFLAG) rd_val = {7'h00, check_err_flag};
		else if (link.addr == cdr_pkg::ADDR_CHK_LD1) rd_val = check_loaded[15:8];
		else if (link.addr == cdr_pkg::ADDR_CHK_LD2) rd_val = check_loaded[23:16];
		else if (link.addr == cdr_pkg::ADDR_CHK_LD3) rd_val = check_loaded[31:24];
		else if (link.addr == cdr_pkg::ADDR_REV) rd_val = REV_VALUE;
		else if (link.addr == cdr_pkg::ADDR_PART) rd_val = PART_VALUE;
		else if (rslot != cdr_pkg::SLOT_NONE) rd_val = mem_reg[rslot];
	end

	////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		ack_next = take;
		rdata_next = (take && !link.we) ? rd_val : rdata_reg;
		mem_next = mem_reg;
		mode_next = mode_reg;
		sticky_next = sticky_reg;
		rate_done_next = rate_done_reg;
		rate_val_next = rate_val_reg;
		start_next = 1'b0;
		clr_next = 1'b0;
		swrst_next = 1'b0;
		if (swrst_reg) begin
			// software reset returns every control field to its reset value
			for (int i = 0; i < cdr_pkg::NUM_RW; i++) begin
				mem_next[i] = rw_default(i);
			end
			mode_next = cdr_pkg::MODE_RST;
			sticky_next = 1'b0;
			rate_done_next = 1'b0;
			rate_val_next = 24'h000000;
		end else begin
			// only mapped read/write slots store; read-only addresses fall through
			if (wslot != cdr_pkg::SLOT_NONE) begin
				mem_next[wslot] = link.wdata;
			end
			// a falling software-reset bit fires the reset one cycle later
			if (wslot == cdr_pkg::SLOT_CTRLB && !link.wdata[cdr_pkg::CTLB_SWRST]
				&& mem_reg[cdr_pkg::SLOT_CTRLB][cdr_pkg::CTLB_SWRST]) begin
				swrst_next = 1'b1;
			end
			if (wr_ctrl) begin
				// reserved codes are the host's to avoid; stored as written
				mode_next = link.wdata[cdr_pkg::CTL_MODE_LSB +: 3];
				start_next = link.wdata[cdr_pkg::CTL_RATE_START];
				clr_next = link.wdata[cdr_pkg::CTL_RATE_CLR];
				if (link.wdata[cdr_pkg::CTL_CLR_STICKY]) sticky_next = 1'b0;
				if (link.wdata[cdr_pkg::CTL_RATE_CLR]) begin
					rate_done_next = 1'b0;
					rate_val_next = 24'h000000;
				end
			end
			// events win over a clear in the same cycle
			if (unlock_s && !unlock_d_reg) sticky_next = 1'b1;
			if (rate_measure_done_in) begin
				rate_done_next = 1'b1;
				rate_val_next = rate_value_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_reg <= 1'b0;
			rdata_reg <= 8'h00;
			for (int i = 0; i < cdr_pkg::NUM_RW; i++) begin
				mem_reg[i] <= rw_default(i);
			end
			mode_reg <= cdr_pkg::MODE_RST;
			sticky_reg <= 1'b0;
			rate_done_reg <= 1'b0;
			rate_val_reg <= 24'h000000;
			unlock_d_reg <= 1'b0;
			start_reg <= 1'b0;
			clr_reg <= 1'b0;
			swrst_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			mem_reg <= mem_next;
			mode_reg <= mode_next;
			sticky_reg <= sticky_next;
			rate_done_reg <= rate_done_next;
			rate_val_reg <= rate_val_next;
			unlock_d_reg <= unlock_s;
			start_reg <= start_next;
			clr_reg <= clr_next;
			swrst_reg <= swrst_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs, all straight from flops

	assign link.ack = ack_reg;
	assign link.rdata = rdata_reg;
	assign recovery_mode_select = mode_reg;
	assign rate_measure_start = start_reg;
	assign rate_measure_clear = clr_reg;
	assign soft_reset = swrst_reg;
	assign signal_loss_data = mem_reg[0];
	assign signal_loss_threshold = mem_reg[cdr_pkg::SLOT_THRESH];
	assign pattern_gen_control = mem_reg[2];
	assign pattern_gen_length = mem_reg[3];
	assign pattern_gen_data = {mem_reg[7], mem_reg[6], mem_reg[5], mem_reg[4]};
	assign pattern_check_control = mem_reg[8];
	assign signal_loss_control = mem_reg[9];
	assign general_control_b = mem_reg[cdr_pkg::SLOT_CTRLB];
endmodule

// [rtl/cdr_pkg.sv]
// shared constants for the recovery-receiver register slice and its host controller
package cdr_pkg;
	// device register offsets on the link
	localparam logic [7:0] ADDR_RATE0 = 8'h00;
	localparam logic [7:0] ADDR_RATE1 = 8'h01;
	localparam logic [7:0] ADDR_RATE2 = 8'h02;
	localparam logic [7:0] ADDR_STATUS = 8'h06;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_CTRLB = 8'h09;
	localparam logic [7:0] ADDR_CODE_HI = 8'h20;
	localparam logic [7:0] ADDR_CODE_LO = 8'h21;
	localparam logic [7:0] ADDR_SIGLOSS_DATA = 8'h36;
	localparam logic [7:0] ADDR_SIGLOSS_THRESH = 8'h38;
	localparam logic [7:0] ADDR_GEN_CTL = 8'h39;
	localparam logic [7:0] ADDR_GEN_LEN = 8'h3a;
	localparam logic [7:0] ADDR_GEN_B0 = 8'h3b;
	localparam logic [7:0] ADDR_GEN_B1 = 8'h3c;
	localparam logic [7:0] ADDR_GEN_B2 = 8'h3d;
	localparam logic [7:0] ADDR_GEN_B3 = 8'h3e;
	localparam logic [7:0] ADDR_CHK_CTL = 8'h3f;
	localparam logic [7:0] ADDR_CHK_ERRCNT = 8'h40;
	localparam logic [7:0] ADDR_CHK_ERRFLAG = 8'h41;
	localparam logic [7:0] ADDR_CHK_LD1 = 8'h43;
	localparam logic [7:0] ADDR_CHK_LD2 = 8'h44;
	localparam logic [7:0] ADDR_CHK_LD3 = 8'h45;
	localparam logic [7:0] ADDR_REV = 8'h48;
	localparam logic [7:0] ADDR_PART = 8'h49;
	localparam logic [7:0] ADDR_SIGLOSS_CTRL = 8'h74;
	// status and control bit positions
	localparam int ST_LOST = 5;
	localparam int ST_UNLOCK = 4;
	localparam int ST_SIGLOSS_DONE = 3;
	localparam int ST_STICKY = 2;
	localparam int ST_RATE_DONE = 0;
	localparam int CTL_MODE_LSB = 4;
	localparam int CTL_CLR_STICKY = 2;
	localparam int CTL_RATE_START = 1;
	localparam int CTL_RATE_CLR = 0;
	localparam int CTLB_SWRST = 7;
	// recovery modes and reset values
	localparam logic [2:0] MODE_DATA = 3'h1;
	localparam logic [2:0] MODE_REF = 3'h3;
	localparam logic [2:0] MODE_RST = 3'h1;
	localparam logic [7:0] THRESH_RST = 8'h0a;
	localparam logic [7:0] RW_RST = 8'h00;
	// generic read/write storage slots
	localparam int NUM_RW = 11;
	localparam logic [3:0] SLOT_NONE = 4'hf;
	localparam logic [3:0] SLOT_THRESH = 4'h1;
	localparam logic [3:0] SLOT_CTRLB = 4'ha;
	// host wishbone offsets and interrupt bits
	localparam logic [7:0] WB_CMD = 8'h00;
	localparam logic [7:0] WB_STAT = 8'h04;
	localparam logic [7:0] WB_IRQ_ST = 8'h08;
	localparam logic [7:0] WB_IRQ_CLR = 8'h0c;
	localparam logic [7:0] WB_IRQ_EN = 8'h10;
	localparam logic [7:0] WB_SWRST = 8'h14;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_REFUSED = 1;
	localparam int CMD_WE = 16;
	localparam logic [7:0] SWRST_SET = 8'h80;
	localparam logic [7:0] SWRST_REL = 8'h00;
endpackage

// [rtl/cdr_link_if.sv]
// register link between host controller and receiver register slice
`timescale 1ns/1ns
interface cdr_link_if;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack;
	modport dev(input req, input we, input addr, input wdata, output rdata, output ack);
	modport host(output req, output we, output addr, output wdata, input rdata, input ack);
endinterface

// [rtl/cdr_sync2.sv]
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module cdr_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// [rtl/cdr_host_end.sv]
// host controller: wishbone registers in front of the receiver register link
`timescale 1ns/1ns
module cdr_host_end (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// interrupt
	output logic irq,
	// register link
	cdr_link_if.host link
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_XFER = 3'b010,
		ST_GAP = 3'b100
	} cdr_host_state_t;

	cdr_host_state_t state_reg, state_next;
	logic [7:0] addr_reg, addr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic we_reg, we_next;
	logic seq_reg, seq_next;
	logic [7:0] rd_reg, rd_next;
	logic [1:0] irq_st_reg, irq_st_next;
	logic [1:0] irq_en_reg, irq_en_next;
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic wb_take;
	logic wb_wr;
	logic [1:0] ev;
	logic [1:0] clr;
	logic [2:0] new_mode;

	////////////////////////////////////////////////////////////////
	// wishbone decode

	assign wb_take = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wb_wr = wb_take && wb_we_i;
	assign new_mode = wb_dat_i[cdr_pkg::CTL_MODE_LSB +: 3];

	// next values for link sequencer, interrupts and bus answer
	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		we_next = we_reg;
		seq_next = seq_reg;
		rd_next = rd_reg;
		irq_en_next = irq_en_reg;
		ev = 2'b00;
		clr = 2'b00;
		ack_next = wb_take;
		dat_next = dat_reg;
		case (state_reg)
			ST_IDLE: begin
				if (wb_wr && wb_adr_i == cdr_pkg::WB_CMD && (&wb_sel_i[2:0])) begin
					// only the two defined recovery modes may go out
					if (wb_dat_i[cdr_pkg::CMD_WE] && wb_dat_i[15:8] == cdr_pkg::ADDR_CTRL
						&& new_mode != cdr_pkg::MODE_DATA && new_mode != cdr_pkg::MODE_REF) begin
						ev[cdr_pkg::IRQ_REFUSED] = 1'b1;
					end else begin
						// clear-sticky, start and discard bits pass through unchanged
						addr_next = wb_dat_i[15:8];
						wdata_next = wb_dat_i[7:0];
						we_next = wb_dat_i[cdr_pkg::CMD_WE];
						state_next = ST_XFER;
					end
				end else if (wb_wr && wb_adr_i == cdr_pkg::WB_SWRST && wb_sel_i[0] && wb_dat_i[0]) begin
					// reset needs the bit raised then dropped: two writes
					addr_next = cdr_pkg::ADDR_CTRLB;
					wdata_next = cdr_pkg::SWRST_SET;
					we_next = 1'b1;
					seq_next = 1'b1;
					state_next = ST_XFER;
				end
			end
			ST_XFER: begin
				if (link.ack) begin
					if (!we_reg) rd_next = link.rdata;
					if (seq_reg) begin
						wdata_next = cdr_pkg::SWRST_REL;
						seq_next = 1'b0;
						state_next = ST_GAP;
					end else begin
						ev[cdr_pkg::IRQ_DONE] = 1'b1;
						state_next = ST_IDLE;
					end
				end
			end
			ST_GAP: begin
				state_next = ST_XFER;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// commands arriving while busy are dropped and flagged
		if (state_reg != ST_IDLE && wb_wr && (wb_adr_i == cdr_pkg::WB_CMD || wb_adr_i == cdr_pkg::WB_SWRST)) begin
			ev[cdr_pkg::IRQ_REFUSED] = 1'b1;
		end
		if (wb_wr && wb_sel_i[0] && wb_adr_i == cdr_pkg::WB_IRQ_CLR) clr = wb_dat_i[1:0];
		if (wb_wr && wb_sel_i[0] && wb_adr_i == cdr_pkg::WB_IRQ_EN) irq_en_next = wb_dat_i[1:0];
		// set beats clear in the same cycle
		irq_st_next = (irq_st_reg & ~clr) | ev;
		if (wb_take && !wb_we_i) begin
			if (wb_adr_i == cdr_pkg::WB_CMD) dat_next = {15'h0, we_reg, addr_reg, wdata_reg};
			else if (wb_adr_i == cdr_pkg::WB_STAT) dat_next = {16'h0000, rd_reg, 7'h00, state_reg != ST_IDLE};
			else if (wb_adr_i == cdr_pkg::WB_IRQ_ST) dat_next = {30'h0, irq_st_reg};
			else if (wb_adr_i == cdr_pkg::WB_IRQ_EN) dat_next = {30'h0, irq_en_reg};
			else dat_next = 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			addr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			we_reg <= 1'b0;
			seq_reg <= 1'b0;
			rd_reg <= 8'h00;
			irq_st_reg <= 2'b00;
			irq_en_reg <= 2'b00;
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			we_reg <= we_next;
			seq_reg <= seq_next;
			rd_reg <= rd_next;
			irq_st_reg <= irq_st_next;
			irq_en_reg <= irq_en_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs

	assign link.req = (state_reg == ST_XFER);
	assign link.we = we_reg;
	assign link.addr = addr_reg;
	assign link.wdata = wdata_reg;
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign irq = |(irq_st_reg & irq_en_reg);
endmodule

// [sim/cdr_link_asserts.sv]
// checker for the register link between host controller and device slice
`timescale 1ns/1ns
module cdr_link_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// link signals
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ack
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// handshake: one answer per request, one cycle after the take
	ack_pulse_a: assert property (ack |=> !ack) else $error("ack held too long");
	ack_timely_a: assert property (req && !ack |=> ack) else $error("ack not one cycle after take");
	ack_cause_a: assert property ($rose(ack) |-> $past(req)) else $error("ack without request");
	req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
		else $error("request changed before ack");
	req_release_a: assert property (ack |=> !req) else $error("request kept after ack");
	////////////////////////////////////////////////////////////////
	// register content seen on the link
	mode_legal_a: assert property (req && we && addr == cdr_pkg::ADDR_CTRL |->
		wdata[6:4] == cdr_pkg::MODE_DATA || wdata[6:4] == cdr_pkg::MODE_REF) else $error("reserved mode sent");
	ctrl_cmdbits_a: assert property (req && !ack && !we && addr == cdr_pkg::ADDR_CTRL |=>
		ack && rdata[3:0] == 4'h0 && !rdata[7]) else $error("command bits read back nonzero");
	status_spare_a: assert property (req && !ack && !we && addr == cdr_pkg::ADDR_STATUS |=>
		ack && rdata[7:6] == 2'h0 && !rdata[1]) else $error("unused status bits nonzero");
	// a set of the reset bit is always followed by its release
	swrst_pair_a: assert property (req && !ack && we && addr == cdr_pkg::ADDR_CTRLB && wdata[7] |=>
		##[1:20] (req && we && addr == cdr_pkg::ADDR_CTRLB && !wdata[7])) else $error("reset bit not released");
	////////////////////////////////////////////////////////////////
	// main scenarios reached
	ctrl_write_c: cover property (req && ack && we && addr == cdr_pkg::ADDR_CTRL);
	status_read_c: cover property (req && ack && !we && addr == cdr_pkg::ADDR_STATUS);
	swrst_write_c: cover property (req && ack && we && addr == cdr_pkg::ADDR_CTRLB);
endmodule

// [sim/testbench.sv]
// self-checking bench: host controller and device slice joined by the link
`timescale 1ns/1ns
module testbench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, wen = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, wb_dat_o;
	logic wb_ack_o, irq;
	logic sig_lost = 1'b0, lock_lost = 1'b0, act_done = 1'b0, rdone = 1'b0, eflag = 1'b1;
	logic [23:0] rval = 24'h0;
	logic [7:0] ecnt = 8'h5a;
	logic [31:8] loaded = 24'hc3b2a1;
	logic [2:0] mode;
	logic mstart, mclear, srst;
	logic [7:0] thresh;
	int mismatches = 0, n_compared = 0, n_start = 0, n_clear = 0, n_srst = 0;
	always #25 sys_clk = ~sys_clk;
	// pulse outputs are one cycle wide, so count them on every edge
	always @(posedge sys_clk) begin
		if (mstart === 1'b1) n_start++;
		if (mclear === 1'b1) n_clear++;
		if (srst === 1'b1) n_srst++;
	end
	////////////////////////////////////////////////////////////////
	// the two ends and the checker
	cdr_link_if link();
	cdr_host_end cdr_host_end_i(.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
		.wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
		.link(link));
	cdr_dev_end cdr_dev_end_i(.sys_clk(sys_clk), .rst(rst), .link(link), .signal_loss_pin(sig_lost),
		.lock_loss_pin(lock_lost), .signal_loss_action_done_pin(act_done), .rate_measure_done_in(rdone),
		.rate_value_in(rval), .check_err_count(ecnt), .check_err_flag(eflag), .check_loaded(loaded),
		.recovery_mode_select(mode), .rate_measure_start(mstart), .rate_measure_clear(mclear),
		.soft_reset(srst), .signal_loss_data(),
		.signal_loss_threshold(thresh), .signal_loss_control(), .pattern_gen_control(), .pattern_gen_length(),
		.pattern_gen_data(), .pattern_check_control(), .general_control_b());
	cdr_link_asserts cdr_link_asserts_i(.sys_clk(sys_clk), .rst(rst), .req(link.req), .we(link.we),
		.addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
	////////////////////////////////////////////////////////////////
	// verdict and comparison
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////
	// bus access: one classic wishbone cycle, then a link transfer through the command register
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		wen <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 40);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 40) begin
			mismatches++;
			summarize();
		end
	endtask
	task automatic wbw(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic wait_idle(output logic [7:0] q);
		logic [31:0] s;
		int n;
		n = 0;
		do begin
			wb(1'b0, cdr_pkg::WB_STAT, 32'h0, s);
			n++;
		end while (s[0] !== 1'b0 && n < 20);
		q = s[15:8];
		if (n >= 20) begin
			mismatches++;
			summarize();
		end
	endtask
	task automatic lop(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		wbw(cdr_pkg::WB_CMD, {15'h0, w, a, d});
		wait_idle(q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		lop(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		lop(1'b0, a, 8'h00, q);
	endtask
	////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_status();
		logic [7:0] q;
		sig_lost <= 1'b1;
		lock_lost <= 1'b1;
		act_done <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd(cdr_pkg::ADDR_STATUS, q);
		check(q, 8'h3c);
		sig_lost <= 1'b0;
		lock_lost <= 1'b0;
		act_done <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd(cdr_pkg::ADDR_STATUS, q);
		check(q, 8'h04);
		rd(cdr_pkg::ADDR_STATUS, q);
		check(q, 8'h04);
		wr(cdr_pkg::ADDR_CTRL, 8'h14);
		rd(cdr_pkg::ADDR_STATUS, q);
		check(q, 8'h00);
		$display("status test done");
	endtask
	task automatic t_rate();
		logic [7:0] q;
		wr(cdr_pkg::ADDR_CTRL, 8'h12);
		check(n_start, 1);
		rval <= 24'h123456;
		rdone <= 1'b1;
		@(posedge sys_clk);
		rdone <= 1'b0;
		rd(cdr_pkg::ADDR_STATUS, q);
		check(q, 8'h01);
		rd(cdr_pkg::ADDR_RATE2, q);
		check(q, 8'h12);
		wr(cdr_pkg::ADDR_CTRL, 8'h11);
		check(n_clear, 1);
		rd(cdr_pkg::ADDR_STATUS, q);
		check(q, 8'h00);
		rd(cdr_pkg::ADDR_RATE0, q);
		check(q, 8'h00);
		$display("rate test done");
	endtask
	task automatic t_mode();
		logic [7:0] q;
		logic [31:0] s;
		logic [2:0] codes [2] = '{cdr_pkg::MODE_REF, cdr_pkg::MODE_DATA};
		wbw(cdr_pkg::WB_IRQ_EN, 32'h3);
		foreach (codes[i]) begin
			wr(cdr_pkg::ADDR_CTRL, {1'b0, codes[i], 4'h0});
			rd(cdr_pkg::ADDR_CTRL, q);
			check(q, {1'b0, codes[i], 4'h0});
			@(negedge sys_clk);
			check(mode, codes[i]);
			check(irq, 1'b1);
		end
		wbw(cdr_pkg::WB_IRQ_CLR, 32'h3);
		@(negedge sys_clk);
		check(irq, 1'b0);
		// a reserved code must be stopped by the host and flagged
		wbw(cdr_pkg::WB_CMD, {15'h0, 1'b1, cdr_pkg::ADDR_CTRL, 8'h50});
		wb(1'b0, cdr_pkg::WB_IRQ_ST, 32'h0, s);
		check(s, 32'h2);
		@(negedge sys_clk);
		check(irq, 1'b1);
		wbw(cdr_pkg::WB_IRQ_EN, 32'h1);
		@(negedge sys_clk);
		check(irq, 1'b0);
		check(mode, cdr_pkg::MODE_DATA);
		wbw(cdr_pkg::WB_IRQ_CLR, 32'h3);
		wb(1'b0, 8'h18, 32'h0, s);
		check(s, 32'h0);
		$display("mode and interrupt test done");
	endtask
	task automatic t_readonly();
		logic [7:0] q;
		wr(cdr_pkg::ADDR_STATUS, 8'hff);
		wr(cdr_pkg::ADDR_REV, 8'hff);
		wr(cdr_pkg::ADDR_CHK_ERRCNT, 8'hff);
		rd(cdr_pkg::ADDR_STATUS, q);
		check(q, 8'h00);
		rd(cdr_pkg::ADDR_REV, q);
		check(q, 8'h01);
		rd(cdr_pkg::ADDR_CHK_ERRCNT, q);
		check(q, 8'h5a);
		$display("read-only test done");
	endtask
	task automatic t_swrst();
		logic [7:0] q;
		logic [31:0] s;
		wr(cdr_pkg::ADDR_SIGLOSS_THRESH, 8'h77);
		check(thresh, 8'h77);
		wr(cdr_pkg::ADDR_CTRL, 8'h30);
		lock_lost <= 1'b1;
		repeat (3) @(posedge sys_clk);
		lock_lost <= 1'b0;
		repeat (4) @(posedge sys_clk);
		// sticky must really be set, or the cleared status after reset proves nothing
		rd(cdr_pkg::ADDR_STATUS, q);
		check(q, 8'h04);
		wbw(cdr_pkg::WB_SWRST, 32'h1);
		// a command inside the two-write reset sequence is refused and never reaches the device
		wbw(cdr_pkg::WB_CMD, {15'h0, 1'b1, cdr_pkg::ADDR_CTRL, 8'h30});
		wait_idle(q);
		wb(1'b0, cdr_pkg::WB_IRQ_ST, 32'h0, s);
		check(s[1], 1'b1);
		check(n_srst, 1);
		rd(cdr_pkg::ADDR_SIGLOSS_THRESH, q);
		check(q, cdr_pkg::THRESH_RST);
		check(thresh, cdr_pkg::THRESH_RST);
		rd(cdr_pkg::ADDR_CTRL, q);
		check(q, 8'h10);
		rd(cdr_pkg::ADDR_STATUS, q);
		check(q, 8'h00);
		$display("software reset test done");
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		t_status();
		t_rate();
		t_mode();
		t_readonly();
		t_swrst();
		summarize();
	end
endmodule
